/* rtl/clock_prescale_sleep_ctrl.v */
`timescale 1ns/10ps
`include "clock_prescale_sleep_defs.vh"

module clock_prescale_sleep_ctrl (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // fuse pin
  input  wire        divide_by_eight_fuse,
  // cpu side
  input  wire        sleep_instr,
  input  wire        wake_irq,
  // clock and power outputs
  output reg         sys_clk_en,
  output reg         cpu_hold,
  output reg         asleep,
  output reg  [2:0]  active_sleep_mode,
  output reg         resume_pulse
);

  localparam [1:0] ST_RUN   = 2'd0;
  localparam [1:0] ST_SLEEP = 2'd1;
  localparam [1:0] ST_WAKE  = 2'd2;

  // a mode code that names no sleep mode never puts the device to sleep
  function mode_valid;
    input [2:0] m;
    begin
      mode_valid = (m == `MODE_IDLE) || (m == `MODE_NOISE_RED) || (m == `MODE_POWER_DOWN) ||
                   (m == `MODE_POWER_SAVE) || (m == `MODE_STANDBY);
    end
  endfunction

  // divider limit for a select value; reserved codes run as divide by 256
  function [7:0] div_limit;
    input [3:0] s;
    begin
      if (s >= `PRESCALE_SEL_MAX)
        div_limit = 8'hff;
      else
        div_limit = (8'h01 << s[2:0]) - 8'h01;
    end
  endfunction

  // fuse synchroniser; not reset so it settles while reset is held
  reg        fuse_meta_reg;
  reg        fuse_sync_reg;
  always @(posedge aclk)
  begin
    fuse_meta_reg <= divide_by_eight_fuse;
    fuse_sync_reg <= fuse_meta_reg;
  end

  reg [3:0]  prescale_select_reg;
  reg        prescale_change_enable_reg;
  reg [1:0]  ce_count_reg;
  reg [3:0]  div_sel_reg;
  reg        div_pending_reg;
  reg [7:0]  div_count_reg;
  reg        sleep_enable_reg;
  reg [2:0]  sleep_mode_select_reg;
  reg [1:0]  state_reg;
  reg [3:0]  wake_count_reg;
  reg [3:0]  aw_addr_reg;
  reg [31:0] w_data_reg;
  reg        w_strb0_reg;

  wire aw_held  = ~s_axi_awready;
  wire w_held   = ~s_axi_wready;
  wire wr_fire  = aw_held & w_held & ~s_axi_bvalid;
  wire wr_lane0 = wr_fire & w_strb0_reg;
  wire wr_pre   = wr_lane0 & (aw_addr_reg == `PRESCALE_REG_ADDR);
  wire wr_slp   = wr_lane0 & (aw_addr_reg == `SLEEP_CTRL_REG_ADDR);
  wire wr_ok    = (aw_addr_reg <= `STATUS_REG_ADDR);  // word aligned, so only the mapped words
  wire ce_write  = wr_pre & w_data_reg[`PRESCALE_CE_BIT] &
                   (w_data_reg[6:0] == 7'h00);
  wire sel_write = wr_pre & ~ce_write;
  wire div_tick  = (div_count_reg == div_limit(div_sel_reg));

  // axi write channel: address and data taken in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_addr_reg   <= 4'h0;
      w_data_reg    <= 32'h0000_0000;
      w_strb0_reg   <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awready <= 1'b0;
        aw_addr_reg   <= {s_axi_awaddr[3:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wready <= 1'b0;
        w_data_reg   <= s_axi_wdata;
        w_strb0_reg  <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // axi read channel: data one cycle after the address is taken
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `RESP_OKAY;
      case ({s_axi_araddr[3:2], 2'b00})
        `PRESCALE_REG_ADDR:
          s_axi_rdata <= {24'h00_0000, prescale_change_enable_reg,
                          3'b000, prescale_select_reg};
        `SLEEP_CTRL_REG_ADDR:
          s_axi_rdata <= {28'h000_0000, sleep_mode_select_reg,
                          sleep_enable_reg};
        `STATUS_REG_ADDR:
          s_axi_rdata <= {24'h00_0000, div_sel_reg, 1'b0,
                          div_pending_reg, state_reg};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // prescale register with timed change-enable
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prescale_select_reg <= fuse_sync_reg ? `PRESCALE_SEL_RST_DIV8
                                           : `PRESCALE_SEL_RST_OFF;
      prescale_change_enable_reg <= 1'b0;
      ce_count_reg <= 2'h0;
    end
    else if (sel_write)
    begin
      if (prescale_change_enable_reg)
        prescale_select_reg <= w_data_reg[`PRESCALE_SEL_MSB:0];
      prescale_change_enable_reg <= 1'b0;
    end
    else if (ce_write && !prescale_change_enable_reg)
    begin
      prescale_change_enable_reg <= 1'b1;
      ce_count_reg <= `PRESCALE_CE_CYC;
    end
    else if (prescale_change_enable_reg)
    begin
      // a repeated set lands here and only lets the window run on
      if (ce_count_reg == 2'h0)
        prescale_change_enable_reg <= 1'b0;
      else
        ce_count_reg <= ce_count_reg - 2'h1;
    end
  end

  // new setting adopted only at a tick of the old one, so no period is ever short
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_sel_reg     <= fuse_sync_reg ? `PRESCALE_SEL_RST_DIV8
                                       : `PRESCALE_SEL_RST_OFF;
      div_pending_reg <= 1'b0;
      div_count_reg   <= 8'h00;
      sys_clk_en      <= 1'b0;
    end
    else
    begin
      sys_clk_en <= div_tick;
      if (div_tick)
      begin
        div_count_reg   <= 8'h00;
        div_sel_reg     <= prescale_select_reg;
        div_pending_reg <= 1'b0;
      end
      else
      begin
        div_count_reg   <= div_count_reg + 8'h01;
        div_pending_reg <= (prescale_select_reg != div_sel_reg);
      end
    end
  end

  // sleep control register
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sleep_enable_reg      <= 1'b0;
      sleep_mode_select_reg <= `SLEEP_CTRL_RST;
    end
    else if (wr_slp)
    begin
      sleep_enable_reg      <= w_data_reg[`SLEEP_EN_BIT];
      sleep_mode_select_reg <= w_data_reg[`SLEEP_MODE_MSB:`SLEEP_MODE_LSB];
    end
  end

  // sleep sequencer; it only halts the cpu, never touching its state
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg         <= ST_RUN;
      wake_count_reg    <= 4'h0;
      cpu_hold          <= 1'b0;
      asleep            <= 1'b0;
      active_sleep_mode <= `MODE_IDLE;
      resume_pulse      <= 1'b0;
    end
    else
    begin
      resume_pulse <= 1'b0;
      case (state_reg)
        ST_RUN:
        begin
          if (sleep_instr && sleep_enable_reg &&
              mode_valid(sleep_mode_select_reg))
          begin
            state_reg         <= ST_SLEEP;
            cpu_hold          <= 1'b1;
            asleep            <= 1'b1;
            active_sleep_mode <= sleep_mode_select_reg;
          end
        end
        ST_SLEEP:
        begin
          if (wake_irq)
          begin
            state_reg <= ST_WAKE;
            asleep    <= 1'b0;
            case (active_sleep_mode)
              `MODE_STANDBY:
                wake_count_reg <= `STANDBY_START_CYC + `WAKE_HALT_CYC;
              `MODE_POWER_DOWN, `MODE_POWER_SAVE:
                wake_count_reg <= `OSC_START_CYC + `WAKE_HALT_CYC;
              default:
                wake_count_reg <= `WAKE_HALT_CYC;
            endcase
          end
        end
        ST_WAKE:
        begin
          if (wake_count_reg == 4'h1)
          begin
            state_reg    <= ST_RUN;
            cpu_hold     <= 1'b0;
            resume_pulse <= 1'b1;
          end
          wake_count_reg <= wake_count_reg - 4'h1;
        end
        default:
        begin
          state_reg <= ST_RUN;
          cpu_hold  <= 1'b0;
          asleep    <= 1'b0;
        end
      endcase
    end
  end

endmodule // clock_prescale_sleep_ctrl

/* rtl/clock_prescale_sleep_defs.vh */
`ifndef CLOCK_PRESCALE_SLEEP_DEFS_VH
`define CLOCK_PRESCALE_SLEEP_DEFS_VH

// register byte offsets
`define PRESCALE_REG_ADDR     4'h0
`define SLEEP_CTRL_REG_ADDR   4'h4
`define STATUS_REG_ADDR       4'h8

// prescale register fields
`define PRESCALE_CE_BIT       7
`define PRESCALE_SEL_MSB      3
`define PRESCALE_SEL_RST_OFF  4'h0
`define PRESCALE_SEL_RST_DIV8 4'h3
`define PRESCALE_SEL_MAX      4'h8
`define PRESCALE_CE_CYC       2'h3

// sleep control register fields
`define SLEEP_EN_BIT          0
`define SLEEP_MODE_LSB        1
`define SLEEP_MODE_MSB        3
`define SLEEP_CTRL_RST        3'h0

// sleep mode codes
`define MODE_IDLE             3'h0
`define MODE_NOISE_RED        3'h1
`define MODE_POWER_DOWN       3'h2
`define MODE_POWER_SAVE       3'h3
`define MODE_STANDBY          3'h6

// wake timing, in master clock cycles
`define WAKE_HALT_CYC         4'h4
`define STANDBY_START_CYC     4'h6
`define OSC_START_CYC         4'h6

// axi responses
`define RESP_OKAY             2'h0
`define RESP_SLVERR           2'h2

`endif

/* sim/clock_prescale_sleep_props.sv */
`timescale 1ns/10ps
module clock_prescale_sleep_props (
  // clock and reset
  input logic        aclk,
  input logic        aresetn,
  // read channel
  input logic [3:0]  s_axi_araddr,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  // cpu and clock side
  input logic        sleep_instr,
  input logic        wake_irq,
  input logic        sys_clk_en,
  input logic        cpu_hold,
  input logic        asleep,
  input logic [2:0]  active_sleep_mode,
  input logic        resume_pulse
);
  logic [3:0] rd_addr;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // the answer carries no address, so keep the one taken
  always @(posedge aclk)
    if (s_axi_arvalid && s_axi_arready)
      rd_addr <= s_axi_araddr;
  property p_gate; $rose(asleep) |-> $past(sleep_instr); endproperty
  a_gate: assert property (p_gate) else $error("sleep without instr");
  property p_mode; $rose(asleep) |-> active_sleep_mode inside {0, 1, 2, 3, 6}; endproperty
  a_mode: assert property (p_mode) else $error("reserved mode slept");
  property p_wake4; asleep && wake_irq && active_sleep_mode < 3'h2 |=>
    (!asleep && cpu_hold) ##1 cpu_hold[*3] ##1 (!cpu_hold && resume_pulse); endproperty
  a_wake4: assert property (p_wake4) else $error("short wake timing");
  property p_wake10; asleep && wake_irq && active_sleep_mode > 3'h1 |=>
    (!asleep && cpu_hold) ##1 cpu_hold[*8] ##1 cpu_hold ##1 !cpu_hold; endproperty
  a_wake10: assert property (p_wake10) else $error("long wake timing");
  property p_res; resume_pulse |=> !resume_pulse && !cpu_hold; endproperty
  a_res: assert property (p_res) else $error("resume pulse too long");
  property p_rst; disable iff (1'b0) !aresetn |=> !asleep && !cpu_hold && !resume_pulse;
  endproperty
  a_rst: assert property (p_rst) else $error("reset left sleep");
  property p_slp_hi; s_axi_rvalid && rd_addr == 4'h4 |-> s_axi_rdata[7:4] == 4'h0; endproperty
  a_slp_hi: assert property (p_slp_hi) else $error("sleep upper bits set");
  property p_pre_hi; s_axi_rvalid && rd_addr == 4'h0 |-> s_axi_rdata[6:4] == 3'h0; endproperty
  a_pre_hi: assert property (p_pre_hi) else $error("prescale bits 6:4 set");
  // divide by 256 at most, reserved codes included
  property p_div; sys_clk_en && !cpu_hold |=> ##[0:255] (sys_clk_en || cpu_hold); endproperty
  a_div: assert property (p_div) else $error("divided tick late");
  c_sleep: cover property ($rose(asleep));
  c_res: cover property (resume_pulse);
  c_rd: cover property (s_axi_rvalid && rd_addr == 4'h4);
endmodule // clock_prescale_sleep_props

bind clock_prescale_sleep_ctrl clock_prescale_sleep_props clock_prescale_sleep_props_inst (
  .aclk              (aclk),
  .aresetn           (aresetn),
  .s_axi_araddr      (s_axi_araddr),
  .s_axi_arvalid     (s_axi_arvalid),
  .s_axi_arready     (s_axi_arready),
  .s_axi_rdata       (s_axi_rdata),
  .s_axi_rvalid      (s_axi_rvalid),
  .sleep_instr       (sleep_instr),
  .wake_irq          (wake_irq),
  .sys_clk_en        (sys_clk_en),
  .cpu_hold          (cpu_hold),
  .asleep            (asleep),
  .active_sleep_mode (active_sleep_mode),
  .resume_pulse      (resume_pulse)
);

/* sim/tb_top.sv */
`timescale 1ns/10ps
`include "clock_prescale_sleep_defs.vh"
module tb_top;
  logic        aclk, aresetn, divide_by_eight_fuse, sleep_instr, wake_irq;
  logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, sys_clk_en, cpu_hold, asleep, resume_pulse;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r, b;
  logic [3:0]  strb;
  logic [2:0]  active_sleep_mode;
  integer      n_fail, checked, i;
  localparam [3:0]  pa = `PRESCALE_REG_ADDR;
  localparam [3:0]  sa = `SLEEP_CTRL_REG_ADDR;
  localparam [14:0] modes = {`MODE_STANDBY, `MODE_POWER_SAVE, `MODE_POWER_DOWN,
                             `MODE_NOISE_RED, `MODE_IDLE};
  clock_prescale_sleep_ctrl clock_prescale_sleep_ctrl_inst (
    .aclk                 (aclk),
    .aresetn              (aresetn),
    .s_axi_awaddr         (s_axi_awaddr),
    .s_axi_awvalid        (s_axi_awvalid),
    .s_axi_awready        (s_axi_awready),
    .s_axi_wdata          (s_axi_wdata),
    .s_axi_wstrb          (s_axi_wstrb),
    .s_axi_wvalid         (s_axi_wvalid),
    .s_axi_wready         (s_axi_wready),
    .s_axi_bresp          (s_axi_bresp),
    .s_axi_bvalid         (s_axi_bvalid),
    .s_axi_bready         (s_axi_bready),
    .s_axi_araddr         (s_axi_araddr),
    .s_axi_arvalid        (s_axi_arvalid),
    .s_axi_arready        (s_axi_arready),
    .s_axi_rdata          (s_axi_rdata),
    .s_axi_rresp          (s_axi_rresp),
    .s_axi_rvalid         (s_axi_rvalid),
    .s_axi_rready         (s_axi_rready),
    .divide_by_eight_fuse (divide_by_eight_fuse),
    .sleep_instr          (sleep_instr),
    .wake_irq             (wake_irq),
    .sys_clk_en           (sys_clk_en),
    .cpu_hold             (cpu_hold),
    .asleep               (asleep),
    .active_sleep_mode    (active_sleep_mode),
    .resume_pulse         (resume_pulse)
  );
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    checked = checked + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, strb};
    {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
    while (!(aw && w))
    begin
      @(posedge aclk);
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
      {s_axi_awvalid, s_axi_wvalid} <= {!aw, !w};
    end
    // ready only once both halves are in, so no same-step toggle between calls
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    b = s_axi_bresp;
  endtask
  task rd_chk(input [3:0] a, input [31:0] exp, input string nm);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    r = s_axi_rresp;
    chk(nm, s_axi_rdata, exp);
  endtask
  task div_chk(input [3:0] s);
    integer n;
    wr(pa, 32'h0000_0080);
    wr(pa, {28'h000_0000, s});
    repeat (3) do @(posedge aclk); while (!sys_clk_en);
    n = 0;
    do begin @(posedge aclk); n = n + 1; end while (!sys_clk_en);
    chk("period", n, s > 4'h8 ? 256 : 1 << s);
  endtask
  task sleep_try(input [2:0] m, input en, input exp);
    wr(sa, {28'h000_0000, m, en});
    sleep_instr <= 1'b1;
    @(posedge aclk);
    sleep_instr <= 1'b0;
    @(posedge aclk);
    chk("asleep", asleep, exp);
    if (exp)
      chk("mode", active_sleep_mode, m);
  endtask
  task wake_chk(input [2:0] m);
    integer n;
    n = 0;
    wake_irq <= 1'b1;
    @(posedge aclk);
    wake_irq <= 1'b0;
    while (!resume_pulse && n < 40)
    begin
      @(posedge aclk);
      n = n + 1;
    end
    chk("wake", n, `WAKE_HALT_CYC + 1 + (m > 3'h1 ? `STANDBY_START_CYC : 4'h0));
    chk("hold", cpu_hold, 1'b0);
    wr(sa, {28'h000_0000, m, 1'b0});
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_fail = n_fail + 1;
    print_verdict;
  end
  initial
  begin
    {n_fail, checked} = 64'h0;
    {aresetn, divide_by_eight_fuse, sleep_instr, wake_irq, s_axi_awvalid} = 5'h00;
    {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 4'h0;
    {s_axi_awaddr, s_axi_wstrb, s_axi_araddr, s_axi_wdata} = 44'h0;
    strb = 4'hF;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(pa, 32'h0000_0000, "pre rst");
    rd_chk(sa, 32'h0000_0000, "slp rst");
    wr(pa, 32'h0000_0005);
    rd_chk(pa, 32'h0000_0000, "unguarded");
    wr(pa, 32'h0000_0081);
    wr(pa, 32'h0000_0005);
    rd_chk(pa, 32'h0000_0000, "ce not alone");
    wr(pa, 32'h0000_0080);
    rd_chk(pa, 32'h0000_0080, "ce open");
    repeat (4) @(posedge aclk);
    rd_chk(pa, 32'h0000_0000, "ce timeout");
    wr(pa, 32'h0000_0080);
    wr(pa, 32'h0000_007F);
    wr(pa, 32'h0000_0005);
    rd_chk(pa, 32'h0000_000F, "sel write");
    // the second set falls inside the first window; an extension would let 0x02 land
    for (i = 0; i < 2; i++)
      wr(pa, 32'h0000_0080);
    wr(pa, 32'h0000_0002);
    rd_chk(pa, 32'h0000_000F, "no extend");
    $display("test prescale register done");
    for (i = 9; i >= 0; i--)
      div_chk(i[3:0]);
    rd_chk(4'h8, 32'h0000_0000, "status");
    $display("test division done");
    wr(sa, 32'h0000_00FF);
    chk("wr resp", b, `RESP_OKAY);
    rd_chk(sa, 32'h0000_000F, "slp upper");
    strb = 4'hE;
    wr(sa, 32'h0000_0000);
    strb = 4'hF;
    rd_chk(sa, 32'h0000_000F, "lane off");
    sleep_try(`MODE_IDLE, 1'b0, 1'b0);
    sleep_try(3'h4, 1'b1, 1'b0);
    for (i = 0; i < 5; i++)
    begin
      sleep_try(modes[i*3 +: 3], 1'b1, 1'b1);
      wake_chk(modes[i*3 +: 3]);
    end
    rd_chk(4'hC, 32'h0000_0000, "unmapped");
    chk("unmapped resp", r, `RESP_SLVERR);
    wr(4'hC, 32'h0000_0001);
    chk("unmapped wr resp", b, `RESP_SLVERR);
    $display("test sleep done");
    divide_by_eight_fuse <= 1'b1;
    sleep_try(`MODE_POWER_DOWN, 1'b1, 1'b1);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("reset wake", {cpu_hold, asleep}, 2'b00);
    rd_chk(pa, 32'h0000_0003, "fuse rst");
    wr(pa, 32'h0000_0080);
    wr(pa, 32'h0000_0000);
    rd_chk(pa, 32'h0000_0000, "any sel");
    $display("test reset in sleep done");
    print_verdict;
  end
endmodule // tb_top
